// ==== static_fwd_map.svh ====
/*
 * register map, field positions, reset values and bus widths of the
 * static link forwarding block.
 * assumes: included by bare name wherever the map is needed.
 */
`ifndef STATIC_FWD_MAP_SVH
`define STATIC_FWD_MAP_SVH

// printed offsets are word indices; byte address is four times them
`define SLF_CFG_FIRST_INDEX 10'h0a0
`define SLF_CFG_LAST_INDEX  10'h0a7
`define SLF_ADDR_W          12

// field positions inside one configuration word
`define SLF_EN_BIT          31
`define SLF_PROC_BIT        8
`define SLF_CE_MSB          4
`define SLF_CE_LSB          0

// reset values
`define SLF_EN_RESET        1'h0
`define SLF_PROC_RESET      1'h0
`define SLF_CE_RESET        5'h00

// axi responses
`define SLF_RESP_OKAY       2'h0
`define SLF_RESP_SLVERR     2'h2

// link ids a..h are 0..7; register order is c,d,a,b,g,h,e,f
`define SLF_LINK_TO_REG     3'h2

`endif

// ==== static_fwd_pkg.sv ====
/*
 * types shared by the static link forwarding block.
 * assumes: compiled before the interface and the modules.
 */
package static_fwd_pkg;

   typedef logic [2:0] link_id_t;
   typedef logic [8:0] token_t;      // control flag and one byte
   typedef logic [4:0] chanend_t;

   typedef struct packed {
      logic     en;
      logic     proc;
      chanend_t ce;
   } link_cfg_t;

   typedef struct packed {
      logic     proc;
      chanend_t ce;
      link_id_t link;
      token_t   data;
   } fwd_word_t;

   typedef struct packed {
      link_id_t link;
      token_t   data;
   } route_word_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_ADDR = 2'b01,
      WR_RESP = 2'b11,
      WR_DATA = 2'b10
   } wr_state_t;

   typedef enum logic {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } rd_state_t;

endpackage

// ==== stream_if.sv ====
/*
 * valid/ready word stream between the forwarding core and its buffers.
 * assumes: one source and one sink, both on the same clock.
 */
interface stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== slf_buffer.sv ====
/*
 * two-entry buffer; both ready and valid come straight from flip-flops.
 * assumes: synchronous active-low reset, one clock.
 */
module slf_buffer #(
   parameter int W = 8
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   stream_if.snk     push,
   stream_if.src     pop
);

   typedef struct packed {
      logic [1:0][W-1:0] e;
      logic              v0;
      logic              v1;
   } buf_state_t;

   buf_state_t s;
   buf_state_t next_s;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      // pop first, then the push lands in the lowest free slot
      if (s.v0 && pop.ready) begin
         next_s.e[0] = s.e[1];
         next_s.v0   = s.v1;
         next_s.v1   = 1'b0;
      end
      if (push.valid && !s.v1) begin
         if (!next_s.v0) begin
            next_s.e[0] = push.data;
            next_s.v0   = 1'b1;
         end else begin
            next_s.e[1] = push.data;
            next_s.v1   = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // full only with both slots taken, so ready stays a plain flop
   assign push.ready = !s.v1;
   assign pop.valid  = s.v0;
   assign pop.data   = s.e[0];

endmodule

// ==== static_link_forwarding.sv ====
/*
 * per-link static forwarding: eight configuration words behind an
 * axi4-lite slave steer arriving link tokens either to one channel end
 * of a local processor or on to the routed path.
 * assumes: one 200 mhz clock, synchronous active-low reset, the routed
 * path and the channel ends honour valid/ready.
 */
// Design decision made here: register access over AXI4-Lite.
`include "static_fwd_map.svh"

// Behaviour
// - a token from a link whose static enable is set goes to its configured channel end and never to the routed path.
// - bit 8 of each word is a read-write processor select, zero at reset, naming the local processor that receives the tokens.
// - bits 4:0 of each word are a read-write channel end index, zero at reset, naming where the tokens are delivered.
// - eight consecutive words each control one link, in ascending order for links c, d, a, b, g, h, e and f.
// - enable, processor and channel end all clear at reset, so every link starts out routed.
module static_link_forwarding (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [`SLF_ADDR_W-1:0] awaddr,
   input  wire logic                   wvalid,
   output logic                        wready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   output logic                        bvalid,
   input  wire logic                   bready,
   output logic [1:0]                  bresp,
   input  wire logic                   arvalid,
   output logic                        arready,
   input  wire logic [`SLF_ADDR_W-1:0] araddr,
   output logic                        rvalid,
   input  wire logic                   rready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire static_fwd_pkg::link_id_t in_link,
   input  wire static_fwd_pkg::token_t in_data,
   output logic                        fwd_valid,
   input  wire logic                   fwd_ready,
   output logic                        fwd_proc,
   output static_fwd_pkg::chanend_t    fwd_chanend,
   output static_fwd_pkg::link_id_t    fwd_link,
   output static_fwd_pkg::token_t      fwd_data,
   output logic                        route_valid,
   input  wire logic                   route_ready,
   output static_fwd_pkg::link_id_t    route_link,
   output static_fwd_pkg::token_t      route_data
);
   import static_fwd_pkg::*;

   typedef struct packed {
      link_cfg_t [7:0] cfg;
      wr_state_t       wst;
      logic [2:0]      widx;
      logic            wmapped;
      logic [31:0]     wdata;
      logic [3:0]      wstrb;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      rd_state_t       rst;
      logic            arready;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
      logic            st_valid;
      logic            st_static;
      fwd_word_t       st_word;
      logic            in_ready;
   } core_state_t;

   core_state_t s;
   core_state_t next_s;

   stream_if #(.W($bits(fwd_word_t)))   fwd_push ();
   stream_if #(.W($bits(fwd_word_t)))   fwd_pop ();
   stream_if #(.W($bits(route_word_t))) route_push ();
   stream_if #(.W($bits(route_word_t))) route_pop ();

   ////////////////////////////////////////////////////////////////////////
   // address decode: word index must fall inside the eight-word block
   function automatic logic is_mapped(input logic [`SLF_ADDR_W-1:0] a);
      logic [9:0] idx;
      idx = a[`SLF_ADDR_W-1:2];
      return (idx >= `SLF_CFG_FIRST_INDEX) && (idx <= `SLF_CFG_LAST_INDEX);
   endfunction

   // reserved bits are simply never stored
   function automatic logic [31:0] cfg_word(input link_cfg_t c);
      logic [31:0] w;
      w = '0;
      w[`SLF_EN_BIT] = c.en;
      w[`SLF_PROC_BIT] = c.proc;
      w[`SLF_CE_MSB:`SLF_CE_LSB] = c.ce;
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;

      // write channel: address and data in either order
      unique case (s.wst)
         WR_IDLE: begin
            if (awvalid && s.awready) begin
               next_s.widx    = awaddr[4:2];
               next_s.wmapped = is_mapped(awaddr);
               next_s.wst     = WR_ADDR;
            end
            if (wvalid && s.wready) begin
               next_s.wdata = wdata;
               next_s.wstrb = wstrb;
               next_s.wst   = (next_s.wst == WR_ADDR) ? WR_RESP : WR_DATA;
            end
         end
         WR_ADDR: begin
            if (wvalid && s.wready) begin
               next_s.wdata = wdata;
               next_s.wstrb = wstrb;
               next_s.wst   = WR_RESP;
            end
         end
         WR_DATA: begin
            if (awvalid && s.awready) begin
               next_s.widx    = awaddr[4:2];
               next_s.wmapped = is_mapped(awaddr);
               next_s.wst     = WR_RESP;
            end
         end
         WR_RESP: begin
            if (bready) begin
               next_s.bvalid = 1'b0;
               next_s.wst    = WR_IDLE;
            end
         end
      endcase

      // commit on the cycle both halves are in; strobes guard each lane
      if (s.wst != WR_RESP && next_s.wst == WR_RESP) begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = next_s.wmapped ? `SLF_RESP_OKAY : `SLF_RESP_SLVERR;
         if (next_s.wmapped) begin
            if (next_s.wstrb[0]) begin
               next_s.cfg[next_s.widx].ce =
                  next_s.wdata[`SLF_CE_MSB:`SLF_CE_LSB];
            end
            if (next_s.wstrb[1]) begin
               next_s.cfg[next_s.widx].proc = next_s.wdata[`SLF_PROC_BIT];
            end
            if (next_s.wstrb[3]) begin
               next_s.cfg[next_s.widx].en = next_s.wdata[`SLF_EN_BIT];
            end
         end
      end
      next_s.awready = (next_s.wst == WR_IDLE) || (next_s.wst == WR_DATA);
      next_s.wready  = (next_s.wst == WR_IDLE) || (next_s.wst == WR_ADDR);

      // read channel: one outstanding read, data from a register
      unique case (s.rst)
         RD_IDLE: begin
            if (arvalid && s.arready) begin
               next_s.rdata   = is_mapped(araddr) ?
                                cfg_word(s.cfg[araddr[4:2]]) : 32'h0000_0000;
               next_s.rresp   = is_mapped(araddr) ?
                                `SLF_RESP_OKAY : `SLF_RESP_SLVERR;
               next_s.rvalid  = 1'b1;
               next_s.arready = 1'b0;
               next_s.rst     = RD_RESP;
            end
         end
         RD_RESP: begin
            if (rready) begin
               next_s.rvalid  = 1'b0;
               next_s.arready = 1'b1;
               next_s.rst     = RD_IDLE;
            end
         end
      endcase

      // staging word drains into whichever buffer it was steered to
      if (s.st_valid &&
          (s.st_static ? fwd_push.ready : route_push.ready)) begin
         next_s.st_valid = 1'b0;
      end
      // config sampled per token; register order is link id xor 2
      if (in_valid && s.in_ready) begin
         next_s.st_valid = 1'b1;
         next_s.st_static =
            s.cfg[in_link ^ `SLF_LINK_TO_REG].en;
         next_s.st_word.proc = s.cfg[in_link ^ `SLF_LINK_TO_REG].proc;
         next_s.st_word.ce   = s.cfg[in_link ^ `SLF_LINK_TO_REG].ce;
         next_s.st_word.link = in_link;
         next_s.st_word.data = in_data;
      end
      // registered ready costs every other cycle of throughput
      next_s.in_ready = !next_s.st_valid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s          <= '0;
         s.wst      <= WR_IDLE;
         s.rst      <= RD_IDLE;
         s.awready  <= 1'b1;
         s.wready   <= 1'b1;
         s.arready  <= 1'b1;
         s.in_ready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // static tokens never reach the routed buffer
   assign fwd_push.valid   = s.st_valid && s.st_static;
   assign fwd_push.data    = s.st_word;
   assign route_push.valid = s.st_valid && !s.st_static;
   assign route_push.data  = {s.st_word.link, s.st_word.data};

   slf_buffer #(.W($bits(fwd_word_t))) u_fwd_buf (
      .aclk    (aclk),
      .aresetn (aresetn),
      .push    (fwd_push),
      .pop     (fwd_pop)
   );

   slf_buffer #(.W($bits(route_word_t))) u_route_buf (
      .aclk    (aclk),
      .aresetn (aresetn),
      .push    (route_push),
      .pop     (route_pop)
   );

   assign fwd_pop.ready   = fwd_ready;
   assign route_pop.ready = route_ready;

   ////////////////////////////////////////////////////////////////////////
   assign awready     = s.awready;
   assign wready      = s.wready;
   assign bvalid      = s.bvalid;
   assign bresp       = s.bresp;
   assign arready     = s.arready;
   assign rvalid      = s.rvalid;
   assign rdata       = s.rdata;
   assign rresp       = s.rresp;
   assign in_ready    = s.in_ready;
   assign fwd_valid   = fwd_pop.valid;
   assign {fwd_proc, fwd_chanend, fwd_link, fwd_data} = fwd_pop.data;
   assign route_valid = route_pop.valid;
   assign {route_link, route_data} = route_pop.data;

endmodule

// ==== slf_sink_model.sv ====
/* channel end / routed path sink: takes words, may stall.
   assumes: valid/ready stream, one clock, sync active-low reset. */
module slf_sink_model #(parameter int W = 12) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         slow,
   input  wire logic         valid,
   input  wire logic [W-1:0] data,
   output logic              ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] q[$];
   logic [1:0]   cnt;
   // slow: one take in four cycles, so the buffer ahead fills
   assign ready = !slow || (cnt == 2'h3);
   always @(posedge aclk) begin
      cnt <= aresetn ? cnt + 2'h1 : 2'h0;
      if (aresetn && valid && ready) q.push_back(data);
   end
endmodule

// ==== static_link_forwarding_properties.sv ====
/* concurrent checks on the ports of static_link_forwarding.
   assumes: bound to the top module; names match its ports. */
`include "static_fwd_map.svh"
module slf_props (
   input wire logic                     aclk,
   input wire logic                     aresetn,
   input wire logic                     awvalid,
   input wire logic                     awready,
   input wire logic                     wvalid,
   input wire logic                     wready,
   input wire logic                     bvalid,
   input wire logic                     arvalid,
   input wire logic                     arready,
   input wire logic                     rvalid,
   input wire logic                     in_valid,
   input wire logic                     in_ready,
   input wire logic                     fwd_valid,
   input wire logic                     fwd_ready,
   input wire logic                     route_valid,
   input wire logic                     route_ready,
   input wire logic [`SLF_ADDR_W-1:0]   araddr,
   input wire logic [31:0]              rdata,
   input wire logic [1:0]               rresp,
   input wire static_fwd_pkg::chanend_t fwd_chanend,
   input wire static_fwd_pkg::token_t   fwd_data,
   input wire static_fwd_pkg::token_t   route_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic inmap;
   assign inmap = araddr[11:2] >= `SLF_CFG_FIRST_INDEX
                  && araddr[11:2] <= `SLF_CFG_LAST_INDEX;
   ////////////////////////////////////////
   AST_AFTER_RESET: assert property ($rose(aresetn) |->
      !(fwd_valid || route_valid || bvalid || rvalid))
      else $error("outputs busy after reset");
   AST_WR_ANSWER: assert property (awvalid && awready && wvalid
      && wready |=> bvalid) else $error("no write response");
   AST_RD_OKAY: assert property (arvalid && arready && inmap
      |=> rvalid && rresp == `SLF_RESP_OKAY) else $error("bad read resp");
   AST_RD_UNMAPPED: assert property (arvalid && arready && !inmap
      |=> rvalid && rresp == `SLF_RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_RESERVED_ZERO: assert property (rvalid |->
      rdata[30:9] == 22'h0 && rdata[7:5] == 3'h0)
      else $error("reserved bits set");
   AST_TOKEN_LANDS: assert property (in_valid && in_ready
      && !fwd_valid && !route_valid |-> ##2 (fwd_valid || route_valid))
      else $error("token lost");
   AST_IN_READY_DROP: assert property (in_valid && in_ready
      |=> !in_ready) else $error("in_ready held after take");
   AST_FWD_HOLD: assert property (fwd_valid && !fwd_ready |=>
      fwd_valid && $stable(fwd_data) && $stable(fwd_chanend))
      else $error("forward word dropped");
   AST_ROUTE_HOLD: assert property (route_valid && !route_ready
      |=> route_valid && $stable(route_data)) else $error("route dropped");
   cover property (fwd_valid && fwd_ready);
   cover property (route_valid && route_ready);
   cover property (in_valid && !in_ready);
endmodule
bind static_link_forwarding slf_props chk (.*);

// ==== static_link_forwarding_tb.sv ====
/* self-checking bench: axi4-lite config, tokens into two sinks.
   assumes: design, package, map header and sink model compiled. */
`include "static_fwd_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module static_link_forwarding_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import static_fwd_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, in_valid = 0, slow = 1;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0]  wstrb = 0;
   link_id_t    in_link = 0, fwd_link, route_link;
   token_t      in_data = 0, fwd_data, route_data;
   chanend_t    fwd_chanend;
   logic awready, wready, bvalid, arready, rvalid, in_ready, fwd_valid;
   logic fwd_ready, fwd_proc, route_valid, route_ready;
   logic [1:0]  bresp, rresp;
   int n_mismatch = 0, total_checks = 0;
   int reg_of[8] = '{2, 3, 0, 1, 6, 7, 4, 5}; // link a..h to register
   logic [17:0] exp_f[$];
   logic [11:0] exp_r[$];
   always #2.5 aclk = ~aclk;
   static_link_forwarding uut (.*);
   slf_sink_model #(.W(18)) fsink (.aclk, .aresetn, .slow,
      .valid(fwd_valid), .ready(fwd_ready),
      .data({fwd_proc, fwd_chanend, fwd_link, fwd_data}));
   slf_sink_model #(.W(12)) rsink (.aclk, .aresetn, .slow,
      .valid(route_valid), .data({route_link, route_data}),
      .ready(route_ready));
   ////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n >= 100) begin
         `CHK(n, 0)
         stop_test;
      end
   endtask
   task automatic wr(input logic [9:0] i, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] e);
      int n = 0;
      @(posedge aclk);
      awvalid <= 1; wvalid <= 1; bready <= 1;
      awaddr <= {i, 2'h0}; wdata <= d; wstrb <= s;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!(bready && bvalid) && n < 100);
      bready <= 0;
      tmo(n);
      `CHK(bresp, e)
   endtask
   task automatic rd(input logic [9:0] i, input logic [31:0] d,
                     input logic [1:0] e);
      int n = 0;
      @(posedge aclk);
      arvalid <= 1; rready <= 1; araddr <= {i, 2'h0};
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 0;
      end while (!(rready && rvalid) && n < 100);
      rready <= 0;
      tmo(n);
      `CHK(rdata, d)
      `CHK(rresp, e)
   endtask
   task automatic send(input int l, input int d);
      int n = 0;
      @(posedge aclk);
      in_valid <= 1; in_link <= 3'(l); in_data <= 9'(d);
      do begin
         @(posedge aclk);
         n++;
      end while (!in_ready && n < 100);
      in_valid <= 0;
      tmo(n);
   endtask
   task automatic drain;
      int n = 0;
      while ((fsink.q.size() < exp_f.size() || rsink.q.size() <
              exp_r.size()) && n < 300) begin
         @(posedge aclk);
         n++;
      end
      tmo(n / 3);
      `CHK(fsink.q.size(), exp_f.size())
      `CHK(rsink.q.size(), exp_r.size())
      foreach (exp_f[j]) `CHK(fsink.q[j], exp_f[j])
      foreach (exp_r[j]) `CHK(rsink.q[j], exp_r[j])
   endtask
   ////////////////////////////////////////
   task automatic t_reset;
      for (int k = 0; k < 8; k++) rd(10'h0a0 + 10'(k), 0, 0);
      $display("reset values done");
   endtask
   task automatic t_fields;
      wr(10'h0a0, 32'hffffffff, 4'hf, 2'h0);
      rd(10'h0a0, 32'h8000011f, 2'h0);
      wr(10'h0a0, 32'h0, 4'h6, 2'h0);
      rd(10'h0a0, 32'h8000001f, 2'h0);
      // lane 0 alone moves only the channel end
      wr(10'h0a0, 32'h00000005, 4'h1, 2'h0);
      rd(10'h0a0, 32'h80000005, 2'h0);
      wr(10'h0a8, 32'hffffffff, 4'hf, 2'h2);
      rd(10'h0a8, 32'h0, 2'h2);
      rd(10'h09f, 32'h0, 2'h2);
      rd(10'h0a7, 32'h0, 2'h0);
      $display("fields done");
   endtask
   task automatic t_map;
      int k;
      for (k = 0; k < 8; k++) wr(10'h0a0 + 10'(k),
         32'h80000000 | (k[0] << 8) | (k + 17), 4'hf, 2'h0);
      for (int l = 0; l < 8; l++) begin
         k = reg_of[l];
         exp_f.push_back({k[0], 5'(k + 17), 3'(l), 9'(l * 9 + 1)});
         send(l, l * 9 + 1);
      end
      drain;
      $display("link map done");
   endtask
   task automatic t_route;
      wr(10'h0a3, 32'h0, 4'h8, 2'h0);
      rd(10'h0a3, 32'h00000114, 2'h0);
      exp_r.push_back({3'h1, 9'h1aa});
      send(1, 9'h1aa);
      exp_f.push_back({1'b1, 5'h12, 3'h3, 9'h055});
      send(3, 9'h055);
      slow <= 0;
      drain;
      $display("routed path done");
   endtask
   // every word was written above, so zeros now prove the clear
   task automatic t_midreset;
      aresetn <= 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      for (int k = 0; k < 8; k++) rd(10'h0a0 + 10'(k), 0, 0);
      $display("mid-run reset done");
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      t_reset;
      t_fields;
      t_map;
      t_route;
      t_midreset;
      stop_test;
   end
endmodule
